// ===== hw/dtmf_consts.svh
// Constants of the dual-tone generator: register indexes, field positions,
// reset values, prescaler counts, divider values and the sine table.
// Assumes inclusion by bare name from the design files only.
`ifndef DTMF_CONSTS_SVH
`define DTMF_CONSTS_SVH

// ****************************************************
// Register indexes; byte address is four times index
// ****************************************************
`define IDX_FREQ_SELECT 8'h19
`define IDX_OUT_CONTROL 8'h1A
`define IDX_CLOCK_SELECT 8'h29
`define IDX_STATUS 8'h30
`define ADDR_LSB 2

// ****************************************************
// Field positions and reset values
// ****************************************************
`define ROW_SEL_LO 0
`define ROW_SEL_HI 1
`define COL_SEL_LO 2
`define COL_SEL_HI 3
`define CTRL_ENABLE 1
`define CTRL_ROW_GATE 2
`define CTRL_COL_GATE 3
`define FREQ_SELECT_RST 4'h0
`define OUT_CONTROL_RST 3'h0
`define CLOCK_SELECT_RST 4'h0

// ****************************************************
// Prescaler: a fixed halving stage, then a ten-step stage
// ****************************************************
`define PRE_HALF_LAST 1'h1
`define STAGE_LAST 4'h9
`define STAGE_MID 4'h4

// ****************************************************
// Tone-clock ticks per sine period, one per tone
// ****************************************************
`define ROW1_DIV 9'h120
`define ROW2_DIV 9'h104
`define ROW3_DIV 9'h0EB
`define ROW4_DIV 9'h0D5
`define COL1_DIV 9'h0A5
`define COL2_DIV 9'h096
`define COL3_DIV 9'h087
`define COL4_DIV 9'h07A

// ****************************************************
// Sine wave: 32 four-bit slots, slot k in bits 4k+3..4k
// ****************************************************
`define SLOTS_PER_PERIOD 10'h020
`define SINE_TABLE 128'h7543_2211_1223_4578_9BCD_EEFF_FEED_CB98
`define IDLE_LEVEL 4'h8

// ****************************************************
// Bus answers
// ****************************************************
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// ===== hw/dtmf_pkg.sv
// Types shared by the dual-tone generator files.
// Assumes nothing of its surroundings.
package dtmf_pkg;

  // Tone clock choice, matched to the oscillator frequency
  typedef enum logic [3:0] {
    CLK_OSC_400K = 4'h0,
    CLK_OSC_800K = 4'h1,
    CLK_OSC_2M = 4'h2,
    CLK_OSC_4M = 4'h3
  } clock_choice_t;

  // Read channel of the register slave
  typedef enum logic [0:0] {
    RD_IDLE = 1'b0,
    RD_ANSWER = 1'b1
  } read_state_t;

  typedef logic [3:0] level_t;

endpackage : dtmf_pkg

// ===== hw/tone_channel.sv
// One tone channel: period divider, 32-slot sine counter and ladder code.
// Assumes tick is a one-cycle enable at the tone clock rate.
`timescale 1ns/100ps
`default_nettype none
`include "dtmf_consts.svh"

module tone_channel #(
  parameter int DIV_W = 9
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic tick,
  input wire logic run,
  input wire logic [DIV_W-1:0] divisor,
  output dtmf_pkg::level_t level,
  output logic [4:0] slot
);
  import dtmf_pkg::*;

  // Whole table held as one word so each slot is a plain four-bit select
  localparam logic [127:0] SINE_WAVE = `SINE_TABLE;

  logic [DIV_W:0] phase;
  logic [DIV_W:0] next_phase;

  // Spread the slots over the period so the period is exactly divisor ticks
  always_comb begin
    next_phase = phase + `SLOTS_PER_PERIOD;
  end

  // Slot counter held at its start while the channel is stopped
  always_ff @(posedge sys_clk) begin
    if (rst || !run) begin // see R16
      phase <= '0;
      slot <= 5'h00;
    end else if (tick) begin
      if (next_phase >= {1'b0, divisor}) begin // see R15
        phase <= next_phase - {1'b0, divisor};
        slot <= slot + 5'h01; // see R12
      end else begin
        phase <= next_phase;
      end
    end
  end

  // Ladder code from the sine table, idle level when stopped
  always_ff @(posedge sys_clk) begin
    if (rst || !run) begin
      level <= `IDLE_LEVEL; // see R16
    end else begin
      level <= SINE_WAVE[{slot, 2'b00} +: 4]; // see R10
    end
  end

endmodule : tone_channel
`default_nettype wire

// ===== hw/dtmf_generator.sv
// Dual-tone generator: AXI4-Lite register slave, tone clock prescaler,
// and row and column tone channels driving ladder D/A codes.
// Assumes sys_clk is the oscillator clock and all inputs are synchronous.
//
// Notes on behaviour
// R1 - Four tone clock candidates come from oscillator by halving then fifth or tenth.
// R2 - Clock-select register picks exactly one candidate as the tone clock.
// R3 - Programmable dividers, slot counters and control registers make both tones.
// R4 - Mode register: four bits, write-only, reset zero; high pair column, low pair row.
// R5 - Control register: three bits, write-only, reset zero, lowest position unused.
// R6 - Control bit 3 gates column output, bit 2 gates row output.
// R7 - Control bit 1 enables or disables the whole tone circuit.
// R8 - Software loads clock-select to match the real oscillator before using tones.
// R9 - A wrong clock-select still runs, only tone frequencies deviate.
// R10 - Row and column sines convert through separate ladder converters.
// R11 - Row sine drives row pin, column sine drives column pin.
// R12 - Each sine period is 32 successive amplitude slots.
// R13 - Row tones are 694.44, 769.23, 851.06 and 938.97 Hz.
// R14 - Column tones are 1212.12, 1333.33, 1481.48 and 1639.34 Hz.
// R15 - Tone equals tone clock over divider value, spread over 32 slots.
// R16 - Disabled or ungated tone pin idles and its slot counter restarts.
//
// Chosen here: the AXI4-Lite slave port.
`timescale 1ns/100ps
`default_nettype none
`include "dtmf_consts.svh"

module dtmf_generator #(
  parameter int ADDR_W = 12,
  parameter int DIV_W = 9
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic [2:0] awprot,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [ADDR_W-1:0] araddr,
  input wire logic [2:0] arprot,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  output dtmf_pkg::level_t row_tone_pin,
  output dtmf_pkg::level_t column_tone_pin
);
  import dtmf_pkg::*;

  // ****************************************************
  // Registers
  // ****************************************************
  logic [3:0] tone_frequency_select;
  logic [3:1] tone_output_control;
  logic [3:0] tone_clock_select;

  logic aw_held;
  logic w_held;
  logic [ADDR_W-1:0] aw_addr_q;
  logic [31:0] w_data_q;
  logic w_lane0_q;
  logic do_write;
  logic [7:0] wr_index;
  logic wr_hit;
  read_state_t rd_state;
  logic [7:0] rd_index;

  logic pre_half_cnt;
  logic pre_half_tick;
  logic [3:0] stage_cnt;
  logic tick_div2;
  logic tick_div4;
  logic tick_div10;
  logic tick_div20;
  logic tone_tick;

  logic tone_circuit_enable;
  logic row_output_gate;
  logic column_output_gate;
  logic row_run;
  logic column_run;
  logic [DIV_W-1:0] row_divisor;
  logic [DIV_W-1:0] column_divisor;
  level_t row_level;
  level_t column_level;
  logic [4:0] row_slot;
  logic [4:0] column_slot;

  // ****************************************************
  // Write channel: address and data taken in either order
  // ****************************************************

  // Write strobe once both halves are held and no answer is pending
  always_comb begin
    do_write = aw_held && w_held && !bvalid;
    wr_index = aw_addr_q[`ADDR_LSB +: 8];
    wr_hit = (wr_index == `IDX_FREQ_SELECT) || (wr_index == `IDX_OUT_CONTROL)
      || (wr_index == `IDX_CLOCK_SELECT) || (wr_index == `IDX_STATUS);
  end

  // Ready flags are flops: each drops when its half is taken and returns
  // only after the answer is accepted, so a write is taken once
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      awready <= 1'b1;
    end else if (awvalid && awready) begin
      awready <= 1'b0;
    end else if (bvalid && bready) begin
      awready <= 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      wready <= 1'b1;
    end else if (wvalid && wready) begin
      wready <= 1'b0;
    end else if (bvalid && bready) begin
      wready <= 1'b1;
    end
  end

  // Hold the write address until the response is issued
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      aw_held <= 1'b0;
      aw_addr_q <= '0;
    end else if (awvalid && awready) begin
      aw_held <= 1'b1;
      aw_addr_q <= awaddr;
    end else if (do_write) begin
      aw_held <= 1'b0;
    end
  end

  // Hold the write data and its low byte lane until the response
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      w_held <= 1'b0;
      w_data_q <= 32'h0000_0000;
      w_lane0_q <= 1'b0;
    end else if (wvalid && wready) begin
      w_held <= 1'b1;
      w_data_q <= wdata;
      w_lane0_q <= wstrb[0];
    end else if (do_write) begin
      w_held <= 1'b0;
    end
  end

  // Response follows both halves; unmapped addresses answer with an error
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      bvalid <= 1'b0;
      bresp <= `RESP_OKAY;
    end else if (do_write) begin
      bvalid <= 1'b1;
      bresp <= wr_hit ? `RESP_OKAY : `RESP_SLVERR;
    end else if (bready) begin
      bvalid <= 1'b0;
    end
  end

  // ****************************************************
  // Write-only tone registers
  // ****************************************************

  // Mode register: high pair column, low pair row
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      tone_frequency_select <= `FREQ_SELECT_RST; // see R4
    end else if (do_write && w_lane0_q && wr_index == `IDX_FREQ_SELECT) begin
      tone_frequency_select <= w_data_q[`COL_SEL_HI:`ROW_SEL_LO]; // see R4
    end
  end

  // Control register: bit 0 is not stored
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      tone_output_control <= `OUT_CONTROL_RST; // see R5
    end else if (do_write && w_lane0_q && wr_index == `IDX_OUT_CONTROL) begin
      tone_output_control <= w_data_q[`CTRL_COL_GATE:`CTRL_ENABLE]; // see R5
    end
  end

  // Clock-select register; software must match it to the oscillator
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      tone_clock_select <= `CLOCK_SELECT_RST;
    end else if (do_write && w_lane0_q && wr_index == `IDX_CLOCK_SELECT) begin
      tone_clock_select <= w_data_q[3:0]; // see R8
    end
  end

  // ****************************************************
  // Read channel: write-only registers read as zero
  // ****************************************************
  always_comb begin
    rd_index = araddr[`ADDR_LSB +: 8];
  end

  // One read at a time; status shows the channels' live state
  // Ready is a flop that mirrors the idle state, so the pin has no comb path
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rd_state <= RD_IDLE;
      arready <= 1'b1;
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= `RESP_OKAY;
    end else begin
      case (rd_state)
        RD_IDLE: begin
          if (arvalid) begin
            rd_state <= RD_ANSWER;
            arready <= 1'b0;
            rvalid <= 1'b1;
            rdata <= 32'h0000_0000;
            rresp <= `RESP_OKAY;
            if (rd_index == `IDX_STATUS) begin
              rdata <= {16'h0000, column_slot, row_slot, 4'h0, column_run, row_run};
            end else if (rd_index == `IDX_FREQ_SELECT || rd_index == `IDX_OUT_CONTROL ||
                         rd_index == `IDX_CLOCK_SELECT) begin
              rdata <= 32'h0000_0000;
            end else begin
              rresp <= `RESP_SLVERR;
            end
          end
        end
        RD_ANSWER: begin
          if (rready) begin
            rd_state <= RD_IDLE;
            arready <= 1'b1;
            rvalid <= 1'b0;
          end
        end
        default: begin
          rd_state <= RD_IDLE;
          arready <= 1'b1;
          rvalid <= 1'b0;
        end
      endcase
    end
  end

  // ****************************************************
  // Prescaler: four candidate tone clocks as enable pulses
  // ****************************************************

  // Halving stage common to all four candidates
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      pre_half_cnt <= 1'b0;
    end else begin
      pre_half_cnt <= (pre_half_cnt == `PRE_HALF_LAST) ? 1'b0 : 1'b1; // see R1
    end
  end

  // Ten-step stage counted on halved pulses, giving a second half, fifth, tenth
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      stage_cnt <= 4'h0;
    end else if (pre_half_tick) begin
      stage_cnt <= (stage_cnt == `STAGE_LAST) ? 4'h0 : stage_cnt + 4'h1; // see R1
    end
  end

  always_comb begin
    pre_half_tick = (pre_half_cnt == `PRE_HALF_LAST);
    tick_div2 = pre_half_tick; // see R1
    tick_div4 = pre_half_tick && stage_cnt[0];
    tick_div10 = pre_half_tick && (stage_cnt == `STAGE_MID || stage_cnt == `STAGE_LAST);
    tick_div20 = pre_half_tick && (stage_cnt == `STAGE_LAST);
  end

  // Exactly one candidate feeds the channels; a mismatch only shifts pitch
  always_comb begin
    case (tone_clock_select)
      CLK_OSC_400K: tone_tick = tick_div2; // see R2
      CLK_OSC_800K: tone_tick = tick_div4;
      CLK_OSC_2M: tone_tick = tick_div10;
      CLK_OSC_4M: tone_tick = tick_div20;
      default: tone_tick = tick_div20; // see R9
    endcase
  end

  // ****************************************************
  // Tone selection and gating
  // ****************************************************
  always_comb begin
    tone_circuit_enable = tone_output_control[`CTRL_ENABLE]; // see R7
    row_output_gate = tone_output_control[`CTRL_ROW_GATE]; // see R6
    column_output_gate = tone_output_control[`CTRL_COL_GATE]; // see R6
    row_run = tone_circuit_enable && row_output_gate;
    column_run = tone_circuit_enable && column_output_gate;
  end

  // Row divider values, picked by the low pair
  always_comb begin
    case (tone_frequency_select[`ROW_SEL_HI:`ROW_SEL_LO])
      2'b00: row_divisor = `ROW1_DIV; // see R13
      2'b01: row_divisor = `ROW2_DIV;
      2'b10: row_divisor = `ROW3_DIV;
      default: row_divisor = `ROW4_DIV;
    endcase
  end

  // Column divider values, picked by the high pair
  always_comb begin
    case (tone_frequency_select[`COL_SEL_HI:`COL_SEL_LO])
      2'b00: column_divisor = `COL1_DIV; // see R14
      2'b01: column_divisor = `COL2_DIV;
      2'b10: column_divisor = `COL3_DIV;
      default: column_divisor = `COL4_DIV;
    endcase
  end

  // ****************************************************
  // Tone channels, one converter each
  // ****************************************************
  tone_channel #(
    .DIV_W(DIV_W)
  ) row_channel (
    .sys_clk(sys_clk),
    .rst(rst),
    .tick(tone_tick),
    .run(row_run),
    .divisor(row_divisor),
    .level(row_level),
    .slot(row_slot)
  ); // see R3

  tone_channel #(
    .DIV_W(DIV_W)
  ) column_channel (
    .sys_clk(sys_clk),
    .rst(rst),
    .tick(tone_tick),
    .run(column_run),
    .divisor(column_divisor),
    .level(column_level),
    .slot(column_slot)
  ); // see R3

  // Pins straight from flip-flops, one cycle after the channel code
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      row_tone_pin <= `IDLE_LEVEL;
      column_tone_pin <= `IDLE_LEVEL;
    end else begin
      row_tone_pin <= row_level; // see R11
      column_tone_pin <= column_level; // see R11
    end
  end

endmodule : dtmf_generator
`default_nettype wire

// ===== verification/dtmf_generator_props.sv
// Checker for the dual-tone generator ports: bus handshakes and idle pins.
// Assumes one clock domain with synchronous active-high reset.
`timescale 1ns/100ps
`default_nettype none
module dtmf_generator_props (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic awvalid,
  input wire logic awready,
  input wire logic wvalid,
  input wire logic wready,
  input wire logic [1:0] bresp,
  input wire logic bvalid,
  input wire logic bready,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic [31:0] rdata,
  input wire logic [1:0] rresp,
  input wire logic rvalid,
  input wire logic rready,
  input wire dtmf_pkg::level_t row_tone_pin,
  input wire dtmf_pkg::level_t column_tone_pin
);
  import dtmf_pkg::*;
  // ****************
  // Properties
  // ****************
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  busy_refuse_a: assert property (bvalid |-> !awready && !wready)
    else $error("write taken while answer pending");
  write_answer_a: assert property (awvalid && awready && wvalid && wready |=> !bvalid ##1 bvalid)
    else $error("write answer late or early");
  b_hold_a: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write answer dropped");
  b_drop_a: assert property (bvalid && bready |=> !bvalid)
    else $error("write answer repeated");
  read_answer_a: assert property (arvalid && arready |=> rvalid && !arready)
    else $error("read answer late");
  r_hold_a: assert property (rvalid && !rready |=> rvalid && $stable(rdata) && $stable(rresp))
    else $error("read answer changed");
  r_drop_a: assert property (rvalid && rready |=> !rvalid)
    else $error("read answer repeated");
  idle_reset_a: assert property ($fell(rst) |-> row_tone_pin == 4'h8 && column_tone_pin == 4'h8)
    else $error("tone pins not idle after reset");
  // Main scenarios reached
  cover property (bvalid && bready && bresp == 2'h2);
  cover property (rvalid && rready && rresp == 2'h0);
  cover property (row_tone_pin == 4'hF ##1 column_tone_pin == 4'hF);
endmodule : dtmf_generator_props
bind dtmf_generator dtmf_generator_props dtmf_generator_props_inst (
  .sys_clk(sys_clk), .rst(rst), .awvalid(awvalid), .awready(awready), .wvalid(wvalid),
  .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .arvalid(arvalid),
  .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
  .row_tone_pin(row_tone_pin), .column_tone_pin(column_tone_pin)
);
`default_nettype wire

// ===== verification/tone_line_model.sv
// Line-side model of the switching system: watches one tone pin and
// measures its sine period in clock cycles. Assumes idle level 0x8.
`timescale 1ns/100ps
`default_nettype none
module tone_line_model (
  input wire logic sys_clk,
  input wire dtmf_pkg::level_t tone,
  output int period,
  output int rises,
  output int busy
);
  import dtmf_pkg::*;
  int span;
  level_t last;
  initial begin
    period = 0;
    rises = 0;
    busy = 0;
    span = 0;
    last = 4'h8;
  end
  // One upward pass through mid-level per cycle; a stop may add a stray one
  always @(posedge sys_clk) begin
    span <= span + 1;
    last <= tone;
    if (tone != 4'h8) busy <= busy + 1;
    if (last < 4'h8 && tone >= 4'h8) begin
      period <= span;
      span <= 1;
      rises <= rises + 1;
    end
  end
endmodule : tone_line_model
`default_nettype wire

// ===== verification/dtmf_generator_bench.sv
// Self-checking bench: registers, tone periods, clock choices and gates.
// Assumes design, package, checker and line model compiled first.
`timescale 1ns/100ps
`default_nettype none
module dtmf_generator_bench;
  import dtmf_pkg::*;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic [11:0] awaddr = 12'h000;
  logic [11:0] araddr = 12'h000;
  logic [31:0] wdata = 32'h0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  level_t row_tone_pin, column_tone_pin;
  int row_period, row_rises, row_busy, col_period, col_rises, col_busy;
  int err_count = 0;
  int checks = 0;
  int row_div [4] = '{288, 260, 235, 213};
  int col_div [4] = '{165, 150, 135, 122};
  int tick_div [4] = '{2, 4, 10, 20};
  dtmf_generator dtmf_generator_inst (
    .sys_clk(sys_clk), .rst(rst), .awaddr(awaddr), .awprot(3'h0), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(4'hF), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arprot(3'h0),
    .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .row_tone_pin(row_tone_pin), .column_tone_pin(column_tone_pin)
  );
  tone_line_model tone_line_model_inst (
    .sys_clk(sys_clk), .tone(row_tone_pin), .period(row_period), .rises(row_rises), .busy(row_busy)
  );
  tone_line_model tone_line_model_inst_col (
    .sys_clk(sys_clk), .tone(column_tone_pin), .period(col_period), .rises(col_rises), .busy(col_busy)
  );
  always #5 sys_clk = ~sys_clk;
  // ****************
  // Common tasks
  // ****************
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : end_of_test
  task automatic check(input logic [31:0] seen, input logic [31:0] want, input string what);
    checks++;
    if (seen !== want) begin
      err_count++;
      $display("[ERR] %0t %s: saw %0h want %0h", $time, what, seen, want);
    end
  endtask : check
  // Every open-ended wait goes through here so a hang ends the run
  task automatic step(inout int n);
    @(posedge sys_clk);
    n++;
    if (n > 30000) begin
      err_count++;
      $display("[ERR] %0t wait ran out", $time);
      end_of_test();
    end
  endtask : step
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] want);
    int n;
    bit a_open, w_open;
    n = 0;
    a_open = 1;
    w_open = 1;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (a_open || w_open) begin
      step(n);
      if (a_open && awready) begin
        a_open = 0;
        awvalid <= 1'b0;
      end
      if (w_open && wready) begin
        w_open = 0;
        wvalid <= 1'b0;
      end
    end
    while (!bvalid) step(n);
    bready <= 1'b0;
    check(bresp, want, "write response");
    @(posedge sys_clk);
  endtask : wr
  // Data is judged only on an OKAY answer; write-only places read zero
  task automatic rd(input logic [11:0] a, input logic [1:0] want);
    int n;
    n = 0;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do step(n); while (!arready);
    arvalid <= 1'b0;
    while (!rvalid) step(n);
    rready <= 1'b0;
    check(rresp, want, "read response");
    if (want == 2'h0) check(rdata, 32'h0, "read data");
    @(posedge sys_clk);
  endtask : rd
  // Restart both channels, then time three upward passes on each pin
  task automatic tone(input logic [3:0] csel, input logic [3:0] mode, input int rp, input int cp);
    int n, r0, c0;
    n = 0;
    wr(12'h068, 32'h0, 2'h0);
    wr(12'h0A4, 32'(csel), 2'h0);
    wr(12'h064, 32'(mode), 2'h0);
    wr(12'h068, 32'hE, 2'h0);
    r0 = row_rises;
    c0 = col_rises;
    while (row_rises < r0 + 3 || col_rises < c0 + 3) step(n);
    check(row_period, rp, "row period");
    check(col_period, cp, "column period");
  endtask : tone
  // ****************
  // Scenarios
  // ****************
  task automatic t_regs();
    rd(12'h064, 2'h0);
    rd(12'h068, 2'h0);
    rd(12'h0A4, 2'h0);
    rd(12'h0C0, 2'h0);
    wr(12'h064, 32'hF, 2'h0);
    rd(12'h064, 2'h0);
    wr(12'h100, 32'hF, 2'h2);
    rd(12'h100, 2'h2);
    $display("t_regs done");
  endtask : t_regs
  task automatic t_tones();
    for (int k = 0; k < 4; k++) begin
      tone(4'h0, 4'(k * 5), row_div[k] * 2, col_div[k] * 2);
    end
    $display("t_tones done");
  endtask : t_tones
  task automatic t_clocks();
    for (int c = 0; c < 4; c++) begin
      tone(4'(c), 4'h0, 288 * tick_div[c], 165 * tick_div[c]);
    end
    tone(4'h7, 4'hF, 213 * tick_div[3], 122 * tick_div[3]);
    $display("t_clocks done");
  endtask : t_clocks
  // Each gate alone, enable alone, gates without enable, unused bit
  task automatic t_gates();
    logic [3:0] ctl [5] = '{4'h2, 4'h6, 4'hA, 4'hC, 4'h1};
    int n, r0, c0;
    for (int i = 0; i < 5; i++) begin
      wr(12'h068, 32'h0, 2'h0);
      wr(12'h068, 32'(ctl[i]), 2'h0);
      r0 = row_busy;
      c0 = col_busy;
      n = 0;
      repeat (700) step(n);
      check(row_busy != r0, ctl[i][1] & ctl[i][2], "row gate");
      check(col_busy != c0, ctl[i][1] & ctl[i][3], "column gate");
    end
    $display("t_gates done");
  endtask : t_gates
  initial begin
    repeat (20) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    t_regs();
    t_tones();
    t_clocks();
    t_gates();
    end_of_test();
  end
endmodule : dtmf_generator_bench
`default_nettype wire
